/* verilog/gate_timer_pkg.sv */
// constants for the gated sixteen bit timer block
`default_nettype none
package gate_timer_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] gate_addr = 4'h4;
    localparam logic [3:0] cnt_low_addr = 4'h8;
    localparam logic [3:0] cnt_high_addr = 4'hC;
    localparam logic [3:0] flag_addr = 4'h0 + 4'h0;
    localparam logic [7:0] flags_addr = 8'h10;
    // control register field positions
    localparam int ctl_src_hi = 7;
    localparam int ctl_src_lo = 6;
    localparam int ctl_pre_hi = 5;
    localparam int ctl_pre_lo = 4;
    localparam int ctl_osc_bit = 3;
    localparam int ctl_sync_bit = 2;
    localparam int ctl_on_bit = 0;
    // gate control register field positions
    localparam int gt_en_bit = 7;
    localparam int gt_pol_bit = 6;
    localparam int gt_tgl_bit = 5;
    localparam int gt_spm_bit = 4;
    localparam int gt_go_bit = 3;
    localparam int gt_val_bit = 2;
    localparam int gt_ss_hi = 1;
    localparam int gt_ss_lo = 0;
    // flag register bits
    localparam int fl_ovf_bit = 0;
    localparam int fl_gate_bit = 1;
    // reset values and writable masks
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] gate_reset = 8'h00;
    localparam logic [7:0] ctrl_wmask = 8'hFD;
    // clock source codes
    localparam logic [1:0] src_fosc4 = 2'h0;
    localparam logic [1:0] src_fosc = 2'h1;
    localparam logic [1:0] src_pin = 2'h2;
    localparam logic [1:0] src_capacitive_sense_oscillator = 2'h3;
    // axi responses and the last count of the divide-by-four
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam logic [1:0] div4_last = 2'h3;
endpackage
`default_nettype wire

/* verilog/gated_sixteen_bit_timer_control.sv */
// gated sixteen bit timer with axi4-lite register access
// Overview of operation
// - two-bit field picks counter clock source
// - code 10: pin edges or crystal clock
// - prescaler divides by 1, 2, 4, 8
// - oscillator enable bit powers dedicated oscillator
// - sync bit: one skips, zero synchronises
// - internal sources ignore the sync bit
// - timer on runs; off stops, clears toggle
// - writable bits reset zero; unused bit reads zero
// - gate enable counts only while gate active
// - polarity bit selects active gate level
// - toggle mode flip-flop; held clear when off
// - single-pulse bit hands gate to acquisition
// - status reads one while armed, hardware clears
// - clearing single-pulse mode clears status
// - gate value bit shows live gate
// - gate source: pin, overflow, comparator 1, 2
// - count visible as high and low bytes
// - count wraps to zero, sets overflow flag
// - trailing edge ends acquisition, further ignored
// - gate value falling edge sets gate flag
// - 8-bit overflow makes a gate pulse
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`default_nettype none
module gated_sixteen_bit_timer_control
    import gate_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_clock_pin,
    input wire logic crystal_in_pin,
    output logic crystal_out_pin,
    output logic dedicated_osc_power,
    input wire logic capacitive_sense_oscillator,
    input wire logic gate_input_pin,
    input wire logic eight_bit_timer_wrap,
    input wire logic comparator_one_synced_output,
    input wire logic comparator_two_synced_output
);
    logic [7:0] ctrl_reg;
    logic [7:0] gate_reg;
    logic [15:0] count_reg;
    logic [1:0] flags_reg;
    // two-stage synchronisers for every outside input
    logic [1:0] ext_s, xtal_s, cap_s, gpin_s, wrap_s, c1_s, c2_s;
    logic ext_prev_reg, cap_prev_reg, xtal_prev_reg, sys_prev_reg;
    logic [1:0] div4_reg;
    logic [2:0] pre_reg;
    logic gate_prev_reg, tgl_reg, gval_reg, gval_prev_reg;
    logic spm_run_reg;
    // axi state
    logic aw_hold, w_hold;
    logic [4:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s <= 2'h0;
            xtal_s <= 2'h0;
            cap_s <= 2'h0;
            gpin_s <= 2'h0;
            wrap_s <= 2'h0;
            c1_s <= 2'h0;
            c2_s <= 2'h0;
        end else begin
            ext_s <= {ext_s[0], external_clock_pin};
            xtal_s <= {xtal_s[0], crystal_in_pin};
            cap_s <= {cap_s[0], capacitive_sense_oscillator};
            gpin_s <= {gpin_s[0], gate_input_pin};
            wrap_s <= {wrap_s[0], eight_bit_timer_wrap};
            c1_s <= {c1_s[0], comparator_one_synced_output};
            c2_s <= {c2_s[0], comparator_two_synced_output};
        end
    end

    // every pin passes two flops, so the unsynchronised choice only skips
    // the extra edge-alignment stage below; this is the cost of one clock
    logic on, osc_en, sync_off;
    logic [1:0] src;
    assign on = ctrl_reg[ctl_on_bit];
    assign osc_en = ctrl_reg[ctl_osc_bit];
    assign sync_off = ctrl_reg[ctl_sync_bit];
    assign src = ctrl_reg[ctl_src_hi:ctl_src_lo];

    logic pin_level, pin_edge, ext_edge_sync, clk_edge;
    // crystal or pin level chosen by the oscillator enable
    assign pin_level = osc_en ? xtal_s[1] : ext_s[1];
    assign pin_edge = pin_level & ~(osc_en ? xtal_prev_reg : ext_prev_reg);
    // sync bit only matters for source 10
    assign ext_edge_sync = sync_off ? pin_edge : sys_prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_reg <= 1'b0;
            xtal_prev_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
            sys_prev_reg <= 1'b0;
            div4_reg <= 2'h0;
        end else begin
            ext_prev_reg <= ext_s[1];
            xtal_prev_reg <= xtal_s[1];
            cap_prev_reg <= cap_s[1];
            sys_prev_reg <= pin_edge; // extra alignment to system clock
            div4_reg <= div4_reg + 2'h1;
        end
    end

    // clock source select
    always_comb begin
        case (src)
            src_fosc4: clk_edge = (div4_reg == div4_last);
            src_fosc: clk_edge = 1'b1;
            src_pin: clk_edge = ext_edge_sync;
            src_capacitive_sense_oscillator: clk_edge = cap_s[1] & ~cap_prev_reg;
            default: clk_edge = 1'b0;
        endcase
    end

    // prescaler: divides edges by 1, 2, 4 or 8
    logic pre_tick;
    logic [2:0] pre_mask;
    always_comb begin
        case (ctrl_reg[ctl_pre_hi:ctl_pre_lo])
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            default: pre_mask = 3'h7;
        endcase
    end
    assign pre_tick = clk_edge && ((pre_reg & pre_mask) == pre_mask);
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pre_reg <= 3'h0;
        else if (clk_edge)
            pre_reg <= pre_reg + 3'h1;
    end

    // gate source mux overflow wrap pulse goes high
    logic gate_src, gate_pol, gate_lvl, gate_rise, toggle_on, spm;
    always_comb begin
        case (gate_reg[gt_ss_hi:gt_ss_lo])
            2'h0: gate_src = gpin_s[1];
            2'h1: gate_src = wrap_s[1];
            2'h2: gate_src = c1_s[1];
            default: gate_src = c2_s[1];
        endcase
    end
    // polarity applied before toggle and pulse logic
    assign gate_pol = gate_reg[gt_pol_bit] ? gate_src : ~gate_src;
    assign gate_rise = gate_pol & ~gate_prev_reg;
    assign toggle_on = gate_reg[gt_tgl_bit];
    assign spm = gate_reg[gt_spm_bit];
    assign gate_lvl = toggle_on ? tgl_reg : gate_pol;

    // toggle flip-flop, cleared when toggle mode or timer off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_prev_reg <= 1'b0;
            tgl_reg <= 1'b0;
        end else begin
            gate_prev_reg <= gate_pol;
            if (!toggle_on || !on)
                tgl_reg <= 1'b0;
            else if (gate_rise)
                tgl_reg <= ~tgl_reg;
        end
    end

    // single-pulse: armed waits for a leading edge, then runs until
    // the trailing edge of the gate value
    logic gval_next, go;
    assign go = gate_reg[gt_go_bit];
    always_comb begin
        if (spm)
            gval_next = spm_run_reg & gate_lvl;
        else
            gval_next = gate_lvl;
    end
    logic gval_fall, lvl_prev_reg, lvl_rise;
    assign gval_fall = gval_prev_reg & ~gval_reg;
    // an armed acquisition starts only on a leading edge, so a gate that
    // is already active when software arms it is not measured
    assign lvl_rise = gate_lvl & ~lvl_prev_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spm_run_reg <= 1'b0;
            lvl_prev_reg <= 1'b0;
            gval_reg <= 1'b0;
            gval_prev_reg <= 1'b0;
        end else begin
            gval_reg <= gval_next; // live gate value
            gval_prev_reg <= gval_reg;
            lvl_prev_reg <= gate_lvl;
            if (!spm || !go)
                spm_run_reg <= 1'b0; // ignore events until re-armed
            else if (lvl_rise && !gval_reg)
                spm_run_reg <= 1'b1;
        end
    end

    // axi write channel capture, either order
    logic do_write, wr_ctrl, wr_gate, wr_lo, wr_hi, wr_ok;
    logic [7:0] wbyte;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;
    assign wbyte = w_data_reg[7:0];
    assign wr_ok = do_write && w_strb_reg[0];
    assign wr_ctrl = wr_ok && aw_addr_reg[4:2] == 3'(ctrl_addr[3:2]);
    assign wr_gate = wr_ok && aw_addr_reg[4:2] == 3'(gate_addr[3:2]);
    assign wr_lo = wr_ok && aw_addr_reg[4:2] == 3'(cnt_low_addr[3:2]);
    assign wr_hi = wr_ok && aw_addr_reg[4:2] == 3'(cnt_high_addr[3:2]);
    logic wr_flags;
    assign wr_flags = wr_ok && aw_addr_reg[4:2] == 3'(flags_addr[4:2]);

    // control register; reset only zeroes here
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ctrl_reg <= ctrl_reset;
        else if (wr_ctrl)
            ctrl_reg <= wbyte & ctrl_wmask; // bit 1 reads zero
    end

    // gate control; status cleared on trailing edge or mode clear
    logic trailing;
    assign trailing = spm && spm_run_reg && gval_fall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_reg <= gate_reset;
        end else begin
            if (wr_gate) begin
                gate_reg[7:4] <= wbyte[7:4];
                gate_reg[1:0] <= wbyte[1:0];
                gate_reg[gt_go_bit] <= wbyte[gt_go_bit] & wbyte[gt_spm_bit];
            end
            if (trailing && !(wr_gate && wbyte[gt_go_bit]))
                gate_reg[gt_go_bit] <= 1'b0;
            if (wr_gate && !wbyte[gt_spm_bit])
                gate_reg[gt_go_bit] <= 1'b0;
            gate_reg[gt_val_bit] <= 1'b0;
        end
    end

    // counter: on, prescaled edge, gate condition
    logic cnt_en, wrap;
    assign cnt_en = on && pre_tick && (!gate_reg[gt_en_bit] || gval_reg);
    assign wrap = cnt_en && count_reg == 16'hFFFF;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_reg <= 16'h0000;
        else if (wr_lo)
            count_reg[7:0] <= wbyte;
        else if (wr_hi)
            count_reg[15:8] <= wbyte;
        else if (cnt_en)
            count_reg <= count_reg + 16'h0001; // rolls to zero
    end

    // sticky flags; hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= 2'h0;
        end else begin
            if (wr_flags && wbyte[fl_ovf_bit])
                flags_reg[fl_ovf_bit] <= 1'b0;
            if (wrap)
                flags_reg[fl_ovf_bit] <= 1'b1;
            if (wr_flags && wbyte[fl_gate_bit])
                flags_reg[fl_gate_bit] <= 1'b0;
            if (gval_fall)
                flags_reg[fl_gate_bit] <= 1'b1;
        end
    end

    // oscillator power and crystal drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dedicated_osc_power <= 1'b0;
            crystal_out_pin <= 1'b0;
        end else begin
            dedicated_osc_power <= osc_en;
            crystal_out_pin <= osc_en & ~xtal_s[1];
        end
    end

    // axi write address / data / response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else begin
            s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg[4:2] > 3'h4) ? resp_slverr
                                                         : resp_okay;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read mux; gate value bit inserted live
    logic [7:0] rbyte;
    always_comb begin
        case (s_axi_araddr[4:2])
            3'h0: rbyte = ctrl_reg;
            3'h1: rbyte = {gate_reg[7:3], gval_reg, gate_reg[1:0]};
            3'h2: rbyte = count_reg[7:0];
            3'h3: rbyte = count_reg[15:8];
            3'h4: rbyte = {6'h00, flags_reg};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= resp_okay;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rbyte};
                s_axi_rresp <= (s_axi_araddr[4:2] > 3'h4) ? resp_slverr
                                                          : resp_okay;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/gate_timer_assertions.sv */
// checker of bus and pin relations beside the gated timer block
`default_nettype none
module gate_timer_checker
    import gate_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic crystal_out_pin,
    input wire logic dedicated_osc_power
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // index of the read in flight, so each answer is tied to its address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_reg <= 3'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            idx_reg <= s_axi_araddr[4:2];
        end
    end
    property p_reset_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
            && !dedicated_osc_power; endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    property p_osc_quiet;
        !dedicated_osc_power |-> !crystal_out_pin; endproperty
    a_osc_quiet: assert property (p_osc_quiet)
        else $error("crystal driven while oscillator off");
    property p_byte_wide;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_byte_wide: assert property (p_byte_wide)
        else $error("read data wider than a byte");
    property p_unused_zero;
        s_axi_rvalid && idx_reg == 3'h0 |-> !s_axi_rdata[1]; endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused control bit reads one");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in time");
    property p_bad_index;
        s_axi_rvalid && idx_reg > 3'h4 |-> s_axi_rresp == resp_slverr;
    endproperty
    a_bad_index: assert property (p_bad_index)
        else $error("unmapped read not refused");
    property p_one_beat;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_one_beat: assert property (p_one_beat)
        else $error("read answer repeated");
    property p_ar_pulse;
        s_axi_arready |=> !s_axi_arready; endproperty
    a_ar_pulse: assert property (p_ar_pulse)
        else $error("read address accepted twice");
endmodule

bind gated_sixteen_bit_timer_control gate_timer_checker chk (.aclk,
    .aresetn, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .crystal_out_pin, .dedicated_osc_power);
`default_nettype wire

/* testbench/signal_source_model.sv */
// clock, crystal and gate sources standing outside the timer
`default_nettype none
module signal_source_model (
    input wire logic ext_run,
    input wire logic [3:0] gate_lvl,
    input wire logic crystal_out_pin,
    output logic external_clock_pin,
    output logic crystal_in_pin,
    output logic capacitive_sense_oscillator,
    output logic gate_input_pin,
    output logic eight_bit_timer_wrap,
    output logic comparator_one_synced_output,
    output logic comparator_two_synced_output
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        external_clock_pin = 1'b0;
        capacitive_sense_oscillator = 1'b0;
    end
    // pin clock stands still unless a run of pulses is asked for
    always #130 if (ext_run) external_clock_pin = ~external_clock_pin;
    // sensing oscillator runs free, unrelated in phase to aclk
    always #170 capacitive_sense_oscillator = ~capacitive_sense_oscillator;
    // crystal returns the inverter drive late, so the pair oscillates
    assign #90 crystal_in_pin = crystal_out_pin;
    // gate sources follow the levels the bench requests
    assign gate_input_pin = gate_lvl[0];
    assign eight_bit_timer_wrap = gate_lvl[1];
    assign comparator_one_synced_output = gate_lvl[2];
    assign comparator_two_synced_output = gate_lvl[3];
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the gated sixteen bit timer
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    n_errors++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gate_timer_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_run;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, gate_lvl;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic external_clock_pin, crystal_in_pin, crystal_out_pin;
    logic dedicated_osc_power, capacitive_sense_oscillator;
    logic gate_input_pin, eight_bit_timer_wrap;
    logic comparator_one_synced_output, comparator_two_synced_output;
    logic [7:0] v, v2;
    logic [15:0] c, w;
    int n_errors, checked, i, d;
    logic [7:0] cfg [4] = '{8'h81, 8'h85, 8'h89, 8'hC1};
    gated_sixteen_bit_timer_control dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_clock_pin, .crystal_in_pin, .crystal_out_pin,
        .dedicated_osc_power, .capacitive_sense_oscillator, .gate_input_pin,
        .eight_bit_timer_wrap, .comparator_one_synced_output,
        .comparator_two_synced_output);
    signal_source_model src (.ext_run, .gate_lvl, .crystal_out_pin,
        .external_clock_pin, .crystal_in_pin, .capacitive_sense_oscillator,
        .gate_input_pin, .eight_bit_timer_wrap,
        .comparator_one_synced_output, .comparator_two_synced_output);
    // 25 MHz system clock
    always #20 aclk = ~aclk;
    task automatic wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [7:0] dat);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, dat};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) n_errors++;
        if (n == 50) wrap_up();
        @(posedge aclk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] dat);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        dat = s_axi_rdata[7:0];
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) n_errors++;
        if (n == 50) wrap_up();
        @(posedge aclk);
    endtask
    // count read only while stopped, so the two halves agree
    task automatic rdcnt(output logic [15:0] cnt);
        rd(5'h08, cnt[7:0]);
        rd(5'h0C, cnt[15:8]);
    endtask
    task automatic run(input logic [7:0] ctl, input int cyc);
        wr(5'h08, 8'h00);
        wr(5'h0C, 8'h00);
        wr(5'h00, ctl);
        repeat (cyc) @(posedge aclk);
        wr(5'h00, 8'h00);
        rdcnt(c);
    endtask
    task automatic pulse;
        gate_lvl[0] <= 1'b1;
        repeat (12) @(posedge aclk);
        gate_lvl[0] <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask
    // main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, ext_run, gate_lvl} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(5'h00, v); `CHK("ctrl reset", 8'h00, v)
        `CHK("read okay", resp_okay, last_resp)
        rd(5'h04, v); `CHK("gate reset", 8'h00, v & 8'hFB)
        wr(5'h00, 8'hFE); rd(5'h00, v); `CHK("ctrl rw", 8'hFC, v)
        `CHK("osc power", 1'b1, dedicated_osc_power)
        wr(5'h00, 8'h00); rd(5'h00, v);
        `CHK("osc off", 1'b0, dedicated_osc_power)
        wr(5'h08, 8'h5A); wr(5'h0C, 8'hA5); rdcnt(c);
        `CHK("count bytes", 16'hA55A, c)
        // both internal sources at every prescale, against the plain rate
        for (i = 0; i < 8; i++) begin
            run({1'b0, ~i[2], i[1:0], 4'h1}, 256);
            if (i == 0) w = c;
            // expected count is the plain count over the total division
            d = w / ((1 << i[1:0]) * (i[2] ? 4 : 1));
            `CHK("rate", 1'b1, c + 1 >= d && c <= d + 1)
        end
        `CHK("plain rate", 1'b1, w >= 256 && w <= 266)
        run(8'h45, 256); `CHK("sync ignored", w, c)
        ext_run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            run(cfg[i], 400);
            `CHK("outer source", 1'b1, c != 0)
        end
        ext_run <= 1'b0;
        wr(5'h10, 8'h03); wr(5'h08, 8'hF0); wr(5'h0C, 8'hFF);
        wr(5'h00, 8'h41); repeat (32) @(posedge aclk); wr(5'h00, 8'h00);
        rdcnt(c); `CHK("wrapped", 8'h00, c[15:8])
        rdcnt(w); `CHK("held", c, w)
        rd(5'h10, v); `CHK("overflow flag", 1'b1, v[0])
        // every gate source, closed then open then falling
        for (i = 0; i < 4; i++) begin
            wr(5'h04, {6'h30, i[1:0]}); wr(5'h00, 8'h41); wr(5'h08, 8'h00);
            rd(5'h08, v); `CHK("gate closed", 8'h00, v)
            gate_lvl[i] <= 1'b1;
            repeat (20) @(posedge aclk);
            rd(5'h04, v); `CHK("gate value", 1'b1, v[2])
            wr(5'h10, 8'h02); gate_lvl <= 4'h0; repeat (8) @(posedge aclk);
            rd(5'h10, v); `CHK("gate flag", 1'b1, v[1])
            rd(5'h08, v); `CHK("gate open", 1'b1, v > 8'h0A)
        end
        wr(5'h04, 8'h80); wr(5'h08, 8'h00); repeat (20) @(posedge aclk);
        rd(5'h08, v); `CHK("low polarity", 1'b1, v > 8'h0A)
        // toggle mode holds the gate open from one rise to the next
        wr(5'h04, 8'hE0); wr(5'h08, 8'h00);
        pulse(); rd(5'h04, v); `CHK("toggle held", 1'b1, v[2])
        wr(5'h00, 8'h00); rd(5'h04, v);
        `CHK("toggle cleared", 1'b0, v[2])
        wr(5'h00, 8'h41);
        wr(5'h04, 8'hD8); wr(5'h08, 8'h00);
        rd(5'h04, v); `CHK("armed", 1'b1, v[3])
        pulse(); rd(5'h04, v); `CHK("done", 1'b0, v[3])
        rd(5'h08, v); `CHK("pulse counted", 1'b1, v != 0)
        pulse(); rd(5'h08, v2); `CHK("later pulse", v, v2)
        wr(5'h04, 8'hD8); wr(5'h04, 8'hC8);
        rd(5'h04, v); `CHK("disarmed", 1'b0, v[3])
        rd(5'h14, v); `CHK("unmapped", resp_slverr, last_resp)
        wr(5'h14, 8'h00);
        `CHK("unmapped write", resp_slverr, last_resp)
        wrap_up();
    end
endmodule
`default_nettype wire
